// File: common/adp_pkg.sv
// Purpose: Shared constants, types and helpers of the sample processor.
// Assumes: Two channels of 12-bit two's complement samples.
// Notes: Config registers are written over the serial pins only.
package adp_pkg;

    // ****************************************
    // Widths
    // ****************************************
    localparam int SW = 12;
    localparam int TAPS = 24;
    localparam int HALF = TAPS / 2;
    localparam int CW = 8;
    localparam int COEF_FRAC = 7;
    localparam int GAIN_FRAC = 12;
    localparam int ACC_W = SW + 30;

    // ****************************************
    // Register map and fields
    // ****************************************
    localparam logic [7:0] REG_SOFT = 8'h00;
    localparam int SOFT_BIT = 1;
    localparam logic [7:0] REG_TRIM = 8'h1a;
    localparam logic [7:0] REG_FILT = 8'h1b;
    localparam logic [7:0] REG_BAND = 8'h1d;
    localparam logic [7:0] REG_COEF = 8'h20;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam int GAIN_LSB = 0;
    localparam int TC_LSB = 4;
    localparam int LOWLAT_BIT = 7;
    localparam int DEC_LSB = 0;
    localparam int ODD_BIT = 3;
    localparam int FILT_BIT = 4;
    localparam int SRC_BIT = 5;
    localparam int OFS_BIT = 7;
    localparam int BAND_LSB = 0;
    localparam logic [2:0] DEC_BY2 = 3'h0;
    localparam logic [2:0] DEC_BY4 = 3'h1;
    localparam logic [2:0] DEC_NONE = 3'h3;
    localparam logic [2:0] DEC_BY8 = 3'h4;
    localparam logic [1:0] BAND_HIGH = 2'h1;

    // ****************************************
    // Timing
    // ****************************************
    localparam int LAT_FULL = 14;
    localparam int LAT_LOW = 10;
    // Gain and filter registers plus the output buffer
    localparam int PLINE_D = LAT_FULL - 3;
    localparam int RLINE_D = LAT_LOW - 1;

    // Built-in half tables, centre tap in the top byte
    localparam logic [HALF-1:0][CW-1:0] LP2_HALF =
        96'h281a_08fa_fb02_03ff_fe00_0100;
    localparam logic [HALF-1:0][CW-1:0] LP4_HALF =
        96'h110f_0c09_0502_00ff_ffff_0000;
    localparam logic signed [47:0] SMAX = 48'sh0000_0000_07ff;
    localparam logic signed [47:0] SMIN = 48'shffff_ffff_f800;

    typedef struct packed {
        logic valid;
        logic [1:0][SW-1:0] s;
    } adp_item_type;

    function automatic logic [SW-1:0] adp_sat(input logic signed [47:0] v);
        if (v > SMAX) return SMAX[SW-1:0];
        if (v < SMIN) return SMIN[SW-1:0];
        return v[SW-1:0];
    endfunction

    // Q12 factors for 0.05 dB steps; unused codes give unity
    function automatic logic [13:0] adp_gain(input logic [3:0] code);
        case (code)
            4'h1: return 14'h1018;
            4'h2: return 14'h102f;
            4'h3: return 14'h1047;
            4'h4: return 14'h105f;
            4'h5: return 14'h1077;
            4'h6: return 14'h1090;
            4'h7: return 14'h10a8;
            4'h8: return 14'h10c1;
            4'h9: return 14'h10da;
            4'ha: return 14'h10f3;
            default: return 14'h1000;
        endcase
    endfunction

    function automatic logic [4:0] adp_tc_log2(input logic [2:0] code);
        case (code)
            3'h1: return 5'h1a;
            3'h2: return 5'h19;
            3'h3: return 5'h18;
            3'h4: return 5'h1c;
            3'h5: return 5'h1d;
            default: return 5'h1b;
        endcase
    endfunction

    function automatic logic [3:0] adp_dec_factor(input logic [2:0] code);
        case (code)
            DEC_BY2: return 4'h2;
            DEC_BY4: return 4'h4;
            DEC_BY8: return 4'h8;
            default: return 4'h1;
        endcase
    endfunction

endpackage

// File: design/adp_pair_buf.sv
// Purpose: Two-entry buffer between the sample pipeline and the output.
// Assumes: Both sides on one clock.
// Notes: Ready is a flop, so the filling side sees no combinational path.
`timescale 1ns/100ps
module adp_pair_buf #(
    parameter int W = 24
) (
    // Clock and reset
    input logic clk,
    input logic rst_n,
    // Filling side
    input logic in_valid,
    output logic in_ready,
    input logic [W-1:0] in_data,
    // Draining side
    output logic out_valid,
    input logic out_ready,
    output logic [W-1:0] out_data
);

    typedef struct packed {
        logic [1:0][W-1:0] mem;
        logic [1:0] v;
        logic rdy;
    } adp_buf_state_type;

    localparam adp_buf_state_type RST = '{mem: '0, v: '0, rdy: 1'b1};

    adp_buf_state_type s_q;
    adp_buf_state_type s_d;

    always_comb begin
        s_d = s_q;
        if (s_q.v[0] && out_ready) begin
            s_d.mem[0] = s_q.mem[1];
            s_d.v = {1'b0, s_q.v[1]};
        end
        if (in_valid && s_q.rdy) begin
            if (s_d.v[0]) begin
                s_d.mem[1] = in_data;
                s_d.v[1] = 1'b1;
            end else begin
                s_d.mem[0] = in_data;
                s_d.v[0] = 1'b1;
            end
        end
        // Refuse only when both entries hold data
        s_d.rdy = ~s_d.v[1];
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s_q <= RST;
        end else begin
            s_q <= s_d;
        end
    end

    assign in_ready = s_q.rdy;
    assign out_valid = s_q.v[0];
    assign out_data = s_q.mem[0];

endmodule // adp_pair_buf

// File: design/adp_core.sv
// Purpose: Offset removal, fine gain, FIR and decimation for two channels.
// Assumes: clk is the sample clock; serial pins are asynchronous.
// Notes: Serial clock must be slower than a quarter of clk.
// How it works
// [R1] Gain code scales both channels alike, 0.05 dB a step, 1010 is +0.5 dB.
// [R2] Gain code is 0000 after reset, unity gain.
// [R3] Offset time-constant code picks 2^24 to 2^29 averaging span.
// [R4] Normal path delivers each sample 14 clocks after capture.
// [R5] Low-latency bit bypasses all processing, 10 clock latency.
// [R6] Decimation code 000 halves the rate, built-in or user taps.
// [R7] Decimation code 001 quarters the rate, built-in or user taps.
// [R8] Decimation code 011 keeps full rate, user taps only.
// [R9] Decimation code 100 divides rate by eight, user taps only.
// [R10] Parity bit: clear gives 24 taps, set gives 23 taps.
// [R11] Filter bit set filters samples, clear bypasses the filter.
// [R12] Source bit clear loads built-in tap weights.
// [R13] Source bit set uses user tap registers written earlier.
// [R14] Offset-enable bit turns automatic offset removal on or off.
// [R15] Halving with band 00: low-pass, -6 dB at Fs/4.
// [R16] Halving with band 01: high-pass at Fs/4; 10 and 11 unused.
// [R17] Quartering with band 00: low-pass, -3 dB at Fs/8.
// [R18] Software avoids undefined decimation and gain codes.
// [R19] Serial writes are accepted only while the reset pin is low.
// [R20] Host resets registers by reset pin pulse or software reset.
`timescale 1ns/100ps
module adp_core #(
    parameter int TC_SCALE_DOWN = 0
) (
    // Clock and reset
    input logic clk,
    input logic rst_n,
    // Converter samples
    input logic smp_valid,
    input logic [1:0][adp_pkg::SW-1:0] smp_data,
    output logic smp_ready,
    // Serial configuration pins
    input logic reset_pin,
    input logic sclk_pin,
    input logic serial_data_pin,
    input logic serial_select_pin_n,
    // Output stream
    output logic out_valid,
    input logic out_ready,
    output logic [1:0][adp_pkg::SW-1:0] out_data
);

    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        logic [3:0] sy1;
        logic [3:0] sy2;
        logic [3:0] sy3;
        logic [15:0] sh;
        logic [3:0] bits;
        logic [7:0] trim;
        logic [7:0] filt;
        logic [7:0] band;
        logic [adp_pkg::TAPS-1:0][adp_pkg::CW-1:0] coef;
        logic [1:0][adp_pkg::ACC_W-1:0] acc;
        adp_pkg::adp_item_type inq;
        adp_pkg::adp_item_type gq;
        adp_pkg::adp_item_type fq;
        logic [1:0][adp_pkg::TAPS-1:0][adp_pkg::SW-1:0] taps;
        logic [2:0] phase;
        adp_pkg::adp_item_type [adp_pkg::PLINE_D-1:0] pl;
        adp_pkg::adp_item_type [adp_pkg::RLINE_D-1:0] rl;
        logic [3:0] calm;
        logic [3:0] gap;
    } adp_state_type;

    adp_state_type s_q;
    adp_state_type s_d;

    logic adv;
    logic cap;
    logic pin_rst;
    logic sel;
    logic fall;
    logic wr;
    logic lowlat;
    logic filt;
    logic ofs;
    logic fout;
    logic builtin;
    logic [15:0] word;
    logic [2:0] dec;
    logic [4:0] tcs;
    logic [3:0] fac;
    logic [13:0] gfac;
    logic [adp_pkg::TAPS-1:0][adp_pkg::CW-1:0] ceff;
    logic [1:0][adp_pkg::TAPS-1:0][adp_pkg::SW-1:0] tn;
    logic signed [47:0] xv [2];
    logic signed [47:0] est [2];
    logic signed [47:0] cv [2];
    logic signed [47:0] pv [2];
    logic signed [47:0] fs [2];
    adp_pkg::adp_item_type push;

    // ****************************************
    // Configuration decode
    // ****************************************
    always_comb begin
        lowlat = s_q.trim[adp_pkg::LOWLAT_BIT];
        filt = s_q.filt[adp_pkg::FILT_BIT];
        ofs = s_q.filt[adp_pkg::OFS_BIT];
        dec = s_q.filt[adp_pkg::DEC_LSB +: 3];
        gfac = adp_pkg::adp_gain(s_q.trim[adp_pkg::GAIN_LSB +: 4]); // [R1]
        // Shortening the span keeps simulations of convergence short
        tcs = 5'(adp_pkg::adp_tc_log2(s_q.trim[adp_pkg::TC_LSB +: 3])
              - 5'(TC_SCALE_DOWN)); // [R3]
        fac = adp_pkg::adp_dec_factor(dec); // [R6] [R7] [R8] [R9]
        // Built-in sets exist only for halving and quartering
        builtin = !s_q.filt[adp_pkg::SRC_BIT]
                  && (dec == adp_pkg::DEC_BY2 || dec == adp_pkg::DEC_BY4);
        for (int k = 0; k < adp_pkg::TAPS; k++) begin
            int hi;
            hi = (k < adp_pkg::HALF) ? k : adp_pkg::TAPS - 1 - k;
            if (!builtin) begin
                ceff[k] = s_q.coef[k]; // [R8] [R9] [R13]
            end else if (dec == adp_pkg::DEC_BY4) begin
                ceff[k] = adp_pkg::LP4_HALF[hi]; // [R12] [R17]
            end else if (s_q.band[adp_pkg::BAND_LSB +: 2]
                         == adp_pkg::BAND_HIGH && k % 2 == 1) begin
                ceff[k] = 8'(-adp_pkg::LP2_HALF[hi]); // [R16]
            end else begin
                ceff[k] = adp_pkg::LP2_HALF[hi]; // [R12] [R15]
            end
            if (s_q.filt[adp_pkg::ODD_BIT] && k == adp_pkg::TAPS - 1) begin
                ceff[k] = '0; // [R10]
            end
        end
    end

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        s_d = s_q;
        adv = smp_ready;
        cap = smp_valid && adv;
        // Pin bits: 0 reset, 1 clock, 2 data, 3 select
        s_d.sy1 = {serial_select_pin_n, serial_data_pin, sclk_pin,
                   reset_pin};
        s_d.sy2 = s_q.sy1;
        s_d.sy3 = s_q.sy2;
        pin_rst = s_q.sy2[0];
        sel = ~s_q.sy2[3];
        fall = s_q.sy3[1] && !s_q.sy2[1];
        word = {s_q.sh[14:0], s_q.sy2[2]};
        wr = sel && fall && s_q.bits == 4'hf && !pin_rst; // [R19]
        if (!sel) begin
            s_d.bits = 4'h0;
        end else if (fall) begin
            s_d.sh = word;
            s_d.bits = s_q.bits + 4'h1;
        end
        if (wr) begin
            case (word[15:8])
                adp_pkg::REG_TRIM: s_d.trim = word[7:0];
                adp_pkg::REG_FILT: s_d.filt = word[7:0];
                adp_pkg::REG_BAND: s_d.band = word[7:0];
                adp_pkg::REG_SOFT: begin
                    if (word[adp_pkg::SOFT_BIT]) begin
                        s_d.trim = adp_pkg::REG_RESET; // [R20]
                        s_d.filt = adp_pkg::REG_RESET;
                        s_d.band = adp_pkg::REG_RESET;
                        s_d.coef = '0;
                    end
                end
                default: begin
                    if (word[15:8] >= adp_pkg::REG_COEF && word[15:8]
                        < adp_pkg::REG_COEF + 8'(adp_pkg::TAPS)) begin
                        s_d.coef[word[15:8] - adp_pkg::REG_COEF] =
                            word[7:0]; // [R13]
                    end
                end
            endcase
        end
        // Registers stay at defaults while the reset pin is high
        if (pin_rst) begin
            s_d.trim = adp_pkg::REG_RESET; // [R2] [R20]
            s_d.filt = adp_pkg::REG_RESET;
            s_d.band = adp_pkg::REG_RESET;
            s_d.coef = '0;
        end

        fout = s_q.gq.valid && (!filt || s_q.phase == 3'h0);
        for (int c = 0; c < 2; c++) begin
            xv[c] = 48'(signed'(s_q.inq.s[c]));
            est[c] = 48'(signed'(s_q.acc[c]) >>> tcs); // [R3]
            cv[c] = ofs ? 48'(signed'(adp_pkg::adp_sat(xv[c] - est[c])))
                    : xv[c]; // [R14]
            pv[c] = (cv[c] * 48'(signed'({1'b0, gfac})))
                    >>> adp_pkg::GAIN_FRAC; // [R1]
            fs[c] = '0;
            tn[c][0] = s_q.gq.s[c];
            for (int k = 1; k < adp_pkg::TAPS; k++) begin
                tn[c][k] = s_q.taps[c][k-1];
            end
            for (int k = 0; k < adp_pkg::TAPS; k++) begin
                fs[c] = fs[c] + 48'(signed'(tn[c][k]))
                        * 48'(signed'(ceff[k]));
            end
            fs[c] = fs[c] >>> adp_pkg::COEF_FRAC;
            if (!ofs) begin
                s_d.acc[c] = '0; // [R14]
            end else if (adv && s_q.inq.valid) begin
                s_d.acc[c] = s_q.acc[c] + cv[c][adp_pkg::ACC_W-1:0];
            end
            if (adv) begin
                s_d.gq.s[c] = adp_pkg::adp_sat(pv[c]);
                s_d.fq.s[c] = filt ? adp_pkg::adp_sat(fs[c])
                              : s_q.gq.s[c]; // [R11]
            end
        end

        // Pipeline moves only when the buffer can take a word
        if (adv) begin
            s_d.inq.valid = smp_valid;
            s_d.inq.s = smp_data;
            s_d.gq.valid = s_q.inq.valid;
            s_d.fq.valid = fout; // [R6] [R7] [R8] [R9] [R11]
            if (s_q.gq.valid) begin
                s_d.taps = tn;
            end
            if (s_q.gq.valid && filt) begin
                s_d.phase = (s_q.phase == 3'(fac - 4'h1)) ? 3'h0
                            : s_q.phase + 3'h1;
                s_d.gap = fout ? 4'h0 : s_q.gap + 4'h1;
            end
            s_d.pl[0] = s_q.fq;
            s_d.rl[0] = s_q.inq; // [R5]
            for (int i = 1; i < adp_pkg::PLINE_D; i++) begin
                s_d.pl[i] = s_q.pl[i-1]; // [R4]
            end
            for (int i = 1; i < adp_pkg::RLINE_D; i++) begin
                s_d.rl[i] = s_q.rl[i-1]; // [R5]
            end
        end
        // New settings restart the count; 4'hf marks no output seen yet
        if (!filt || wr) begin
            s_d.phase = 3'h0;
            s_d.gap = 4'hf;
        end
        if (!adv || wr || pin_rst) begin
            s_d.calm = 4'h0;
        end else if (s_q.calm != 4'hf) begin
            s_d.calm = s_q.calm + 4'h1;
        end
        push = lowlat ? s_q.rl[adp_pkg::RLINE_D-1]
               : s_q.pl[adp_pkg::PLINE_D-1]; // [R4] [R5]
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // ****************************************
    // Output buffer
    // ****************************************
    adp_pair_buf #(
        .W(2 * adp_pkg::SW)
    ) u_buf (
        .clk(clk),
        .rst_n(rst_n),
        .in_valid(push.valid),
        .in_ready(smp_ready),
        .in_data(push.s),
        .out_valid(out_valid),
        .out_ready(out_ready),
        .out_data(out_data)
    );

    // ****************************************
    // Checks
    // ****************************************
    a_gain_reset: assert property ( // [R2]
        @(posedge clk) !rst_n |=> s_q.trim[3:0] == 4'h0
    ) else $error("gain code not cleared by reset");

    a_gain_step: assert property ( // [R1]
        @(posedge clk) disable iff (!rst_n)
        (adv && s_q.inq.valid && !ofs && s_q.trim[3:0] == 4'ha
         && s_q.inq.s[0] == 12'h3e8)
        |=> s_q.gq.s[0] == 12'h423
    ) else $error("code 1010 did not give +0.5 dB");

    a_tc_map: assert property ( // [R3]
        @(posedge clk) disable iff (!rst_n)
        (s_q.trim[6:4] == 3'h6 || s_q.trim[6:4] == 3'h0)
        |-> tcs == 5'(27 - TC_SCALE_DOWN)
    ) else $error("offset span code mapped wrongly");

    a_full_latency: assert property ( // [R4]
        @(posedge clk) disable iff (!rst_n)
        (s_q.calm == 4'hf && !lowlat && !filt)
        |-> push.valid == $past(cap, 14)
    ) else $error("normal path latency is not 14");

    a_low_latency: assert property ( // [R5]
        @(posedge clk) disable iff (!rst_n)
        (s_q.calm == 4'hf && lowlat && $past(cap, 10))
        |-> push.valid && push.s == $past(smp_data, 10)
    ) else $error("bypass latency or data wrong");

    a_decim_ratio: assert property ( // [R6] [R7] [R8] [R9]
        @(posedge clk) disable iff (!rst_n)
        (s_q.calm == 4'hf && filt && s_q.gq.valid && fout
         && s_q.gap != 4'hf)
        |-> s_q.gap == fac - 4'h1
    ) else $error("decimation ratio wrong");

    a_odd_taps: assert property ( // [R10]
        @(posedge clk) disable iff (!rst_n)
        s_q.filt[adp_pkg::ODD_BIT] |-> ceff[adp_pkg::TAPS-1] == 8'h00
    ) else $error("odd length still uses last tap");

    a_filter_off: assert property ( // [R11]
        @(posedge clk) disable iff (!rst_n)
        (!filt && adv && s_q.gq.valid)
        |=> s_q.fq.valid && s_q.fq.s == $past(s_q.gq.s)
    ) else $error("filter bypass altered samples");

    a_coef_source: assert property ( // [R12] [R13] [R15] [R16]
        @(posedge clk) disable iff (!rst_n)
        (dec == adp_pkg::DEC_BY2 && !s_q.filt[adp_pkg::ODD_BIT])
        |-> ceff[1] == (s_q.filt[adp_pkg::SRC_BIT] ? s_q.coef[1]
            : (s_q.band[1:0] == adp_pkg::BAND_HIGH
               ? 8'(-adp_pkg::LP2_HALF[1]) : adp_pkg::LP2_HALF[1]))
    ) else $error("tap weight source wrong");

    a_offset_off: assert property ( // [R14]
        @(posedge clk) disable iff (!rst_n)
        !ofs |=> s_q.acc == '0
    ) else $error("offset estimate kept while disabled");

    a_write_gate: assert property ( // [R19] [R20]
        @(posedge clk) disable iff (!rst_n)
        pin_rst |=> s_q.trim == 8'h00 && s_q.filt == 8'h00
    ) else $error("registers written while reset pin high");

endmodule // adp_core

// File: bench/adp_host_model.sv
// Purpose: Host model that writes the config registers over serial pins.
// Assumes: Pins change only just after a clk rising edge.
// Notes: Released pins sit at their pull levels; sclk idles low.
`timescale 1ns/100ps
module adp_host_model (
    // Clock
    input wire logic clk,
    // Serial pins
    output logic reset_pin,
    output logic sclk_pin,
    output logic serial_data_pin,
    output logic serial_select_pin_n
);
    initial begin
        reset_pin = 1'b0;
        sclk_pin = 1'b0;
        serial_data_pin = 1'b0;
        serial_select_pin_n = 1'b1;
    end

    // High-going pulse to clear the registers
    task automatic pulse_reset();
        @(posedge clk);
        reset_pin <= 1'b1;
        repeat (8) @(posedge clk);
        reset_pin <= 1'b0;
        repeat (8) @(posedge clk);
    endtask

    // Address then data, MSB first; bad keeps reset high on purpose
    task automatic write(input logic [7:0] addr, input logic [7:0] data,
            input logic bad);
        logic [15:0] f;
        f = {addr, data};
        @(posedge clk);
        reset_pin <= bad;
        serial_select_pin_n <= 1'b0;
        for (int i = 15; i >= 0; i--) begin
            serial_data_pin <= f[i];
            repeat (4) @(posedge clk);
            sclk_pin <= 1'b1;
            repeat (4) @(posedge clk);
            sclk_pin <= 1'b0;
            repeat (4) @(posedge clk);
        end
        // Pull levels once released
        serial_select_pin_n <= 1'b1;
        serial_data_pin <= 1'b0;
        reset_pin <= 1'b0;
        repeat (8) @(posedge clk);
    endtask
endmodule // adp_host_model

// File: bench/adp_core_bench.sv
// Purpose: Self-checking bench of the sample processor.
// Assumes: User taps stay zero except tap 23.
// Notes: Offset span shortened by 2^20 so it settles quickly.
`timescale 1ns/100ps
module adp_core_bench;
    logic clk;
    logic rst_n;
    logic smp_valid;
    logic smp_ready;
    logic out_valid;
    logic out_ready;
    logic [1:0][adp_pkg::SW-1:0] smp_data;
    logic [1:0][adp_pkg::SW-1:0] out_data;
    logic reset_pin, sclk_pin, serial_data_pin, serial_select_pin_n;
    logic [adp_pkg::SW-1:0] last_a, last_b;
    int n_full = 0;
    int n_mismatch = 0;
    int checks_done = 0;
    int out_cnt = 0;
    int c0;
    logic [7:0] cfg [8] = '{8'h01, 8'h10, 8'h10, 8'h11, 8'h30, 8'h38,
        8'h13, 8'h14};
    logic [7:0] band [8] = '{8'h00, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00,
        8'h00, 8'h00};
    logic [11:0] val_exp [8] = '{12'h200, 12'h210, 12'h000, 12'h1c8,
        12'h100, 12'h000, 12'h100, 12'h100};
    logic [11:0] cnt_exp [8] = '{12'h040, 12'h020, 12'h020, 12'h010,
        12'h020, 12'h020, 12'h040, 12'h008};

    adp_core #(.TC_SCALE_DOWN(20)) u_adp_core (.clk(clk), .rst_n(rst_n),
        .smp_valid(smp_valid), .smp_data(smp_data), .smp_ready(smp_ready),
        .reset_pin(reset_pin), .sclk_pin(sclk_pin),
        .serial_data_pin(serial_data_pin),
        .serial_select_pin_n(serial_select_pin_n), .out_valid(out_valid),
        .out_ready(out_ready), .out_data(out_data));
    adp_host_model u_adp_host_model (.clk(clk), .reset_pin(reset_pin),
        .sclk_pin(sclk_pin), .serial_data_pin(serial_data_pin),
        .serial_select_pin_n(serial_select_pin_n));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    always @(posedge clk) begin
        if (out_valid && out_ready) begin
            out_cnt <= out_cnt + 1;
            last_a <= out_data[0];
            last_b <= out_data[1];
        end
        if (!smp_ready) n_full <= n_full + 1;
    end

    task automatic tally_and_finish();
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic check(input logic [11:0] seen, input logic [11:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h want %h", $time, seen, exp);
        end
    endtask

    // Entered just after an edge; holds until the sample is taken
    task automatic send(input logic [11:0] a, input logic [11:0] b);
        smp_valid <= 1'b1;
        smp_data <= {b, a};
        @(posedge clk);
        while (smp_ready !== 1'b1) @(posedge clk);
    endtask

    task automatic feed(input int n, input logic [11:0] v);
        @(posedge clk);
        for (int i = 0; i < n; i++) send(v, v);
        smp_valid <= 1'b0;
        repeat (60) @(posedge clk);
    endtask

    // One sample, count edges until it shows
    task automatic lat(input int n_exp, input logic [11:0] a, b, ea, eb);
        int n;
        @(posedge clk);
        send(a, b);
        smp_valid <= 1'b0;
        n = 0;
        while (out_valid !== 1'b1 && n < 40) begin
            @(posedge clk);
            #1;
            n++;
        end
        check(12'(n), 12'(n_exp));
        check(out_data[0], ea);
        check(out_data[1], eb);
        repeat (4) @(posedge clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        u_adp_host_model.write(a, d, 1'b0);
    endtask

    initial begin
        repeat (40000) @(posedge clk);
        n_mismatch++;
        tally_and_finish();
    end

    initial begin
        rst_n = 1'b0;
        smp_valid = 1'b0;
        smp_data = '0;
        out_ready = 1'b1;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        u_adp_host_model.pulse_reset();
        lat(14, 12'h064, 12'hffb, 12'h064, 12'hffb);
        wr(adp_pkg::REG_TRIM, 8'h80);
        lat(10, 12'h3e8, 12'hbb8, 12'h3e8, 12'hbb8);
        wr(adp_pkg::REG_TRIM, 8'h8a);
        lat(10, 12'h3e8, 12'hbb8, 12'h3e8, 12'hbb8);
        wr(adp_pkg::REG_TRIM, 8'h0a);
        lat(14, 12'h3e8, 12'hbb8, 12'h423, 12'hb76);
        wr(adp_pkg::REG_SOFT, 8'h02);
        lat(14, 12'h3e8, 12'hbb8, 12'h3e8, 12'hbb8);
        u_adp_host_model.write(adp_pkg::REG_TRIM, 8'h80, 1'b1);
        lat(14, 12'h3e8, 12'h3e8, 12'h3e8, 12'h3e8);
        // Receiver stalls 40 clocks while 30 samples are sent; 16 fit before input backs up
        @(posedge clk);
        out_ready <= 1'b0;
        c0 = out_cnt;
        fork
            begin
                repeat (40) @(posedge clk);
                out_ready <= 1'b1;
            end
            for (int i = 0; i < 30; i++) send(12'(i), 12'(i));
        join
        smp_valid <= 1'b0;
        repeat (40) @(posedge clk);
        check(12'(n_full > 0), 12'h001);
        check(12'(out_cnt - c0), 12'h01e);
        check(last_a, 12'h01d);
        // Only tap 23 set, half scale; defined codes only
        wr(8'h37, 8'h40);
        for (int k = 0; k < 8; k++) begin
            wr(adp_pkg::REG_BAND, band[k]);
            wr(adp_pkg::REG_FILT, cfg[k]);
            c0 = out_cnt;
            feed(64, 12'h200);
            check(12'(out_cnt - c0), cnt_exp[k]);
            check(last_a, val_exp[k]);
            check(last_b, val_exp[k]);
        end
        wr(adp_pkg::REG_TRIM, 8'h30);
        wr(adp_pkg::REG_FILT, 8'h80);
        feed(600, 12'h200);
        check(12'(last_a < 12'h100), 12'h001);
        wr(adp_pkg::REG_FILT, 8'h00);
        feed(64, 12'h200);
        check(last_a, 12'h200);
        tally_and_finish();
    end
endmodule // adp_core_bench
